//--- design/sac_pkg.sv
// Purpose: Shared constants and types for the converter control block
// Assumes: 250 MHz clock, 12-bit successive approximation
// Notes:   Timing counts derive from times in ns, except CLK_LOW_CYC, which is given in cycles
package sac_pkg;

    localparam int          RES_BITS        = 12;
    localparam int          CLK_PERIOD_NS   = 4;
    // Least start pulse width
    localparam int          START_MIN_NS    = 100;
    localparam int          START_MIN_CYC   = (START_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest conversion, slow and fast variants
    localparam int          CONV_SLOW_NS    = 8000;
    localparam int          CONV_FAST_NS    = 4000;
    localparam int          CONV_SLOW_CYC   = CONV_SLOW_NS / CLK_PERIOD_NS;
    localparam int          CONV_FAST_CYC   = CONV_FAST_NS / CLK_PERIOD_NS;
    // Bit period: twelve decisions plus one settle slot must fit, rounded down
    localparam int          BIT_SLOW_CYC    = CONV_SLOW_CYC / (RES_BITS + 1);
    localparam int          BIT_FAST_CYC    = CONV_FAST_CYC / (RES_BITS + 1);
    // Clock-out low phase within a bit period
    localparam int          CLK_LOW_CYC     = 4;
    localparam logic [11:0] RESULT_RST      = 12'h000;
    localparam logic [11:0] MIDSCALE        = 12'h800;

    typedef enum logic {
        SAC_UNIPOLAR,
        SAC_BIPOLAR
    } sac_range_t;

    // Result as seen at the parallel pins
    typedef struct packed {
        logic [11:0] data;
        logic        msb_inv;
    } sac_result_t;

    // Serial stream pins
    typedef struct packed {
        logic        sdata;
        logic        sclk;
    } sac_serial_t;

endpackage

//--- design/sac_sar_reg.sv
// Purpose: Successive approximation register holding trial and decided bits
// Assumes: One decision per decide_in pulse, MSB first
// Notes:   Result comes straight out of a register
`timescale 1ns/100ps
module sac_sar_reg (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // Control
    input  wire logic        clear_in,
    input  wire logic        decide_in,
    input  wire logic [3:0]  index_in,
    input  wire logic        cmp_in,
    // State
    output logic      [11:0] code_out
);

    logic [11:0] code;
    logic [11:0] next_code;

    always_comb begin
        next_code = code;
        if (clear_in) begin
            next_code = sac_pkg::MIDSCALE;
        end else if (decide_in) begin
            next_code[index_in] = cmp_in;
            if (index_in != 4'h0) begin
                next_code[index_in - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            code <= sac_pkg::RESULT_RST;
        end else begin
            code <= next_code;
        end
    end

    assign code_out = code;

endmodule

//--- design/sac_ctrl.sv
// Purpose: Digital control and output side of a 12-bit SAR converter
// Assumes: Comparator result arrives from the analog side as a pin
// Notes:   Start high holds reset; conversion runs after it falls
// Function
// RQ1: Start high resets; falling edge starts conversion
// RQ2: Status high in reset and conversion
// RQ3: Parallel result held until next start
// RQ4: Resolve each sample to twelve bits
// RQ5: Unipolar result is straight binary
// RQ6: Bipolar result is offset binary
// RQ7: Inverted MSB output gives two's complement
// RQ8: Serial NRZ decisions, MSB first
// RQ9: Serial coding matches parallel range coding
// RQ10: Clock out pulses low only during conversion
// RQ11: Conversion within 8 or 4 us
// RQ12: Twelve clock pulses; status falls after last
`timescale 1ns/100ps
module sac_ctrl (
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                rst_in,
    // Host control pins
    input  wire logic                start_in,
    input  wire logic                fast_in,
    input  wire sac_pkg::sac_range_t range_in,
    // Analog side
    input  wire logic                cmp_in,
    output logic [11:0]              dac_code_out,
    // Outputs
    output logic                     status_out,
    output sac_pkg::sac_result_t     result_out,
    output sac_pkg::sac_serial_t     serial_out,
    output logic                     short_start_out
);

    typedef enum logic [1:0] {
        SAC_IDLE,
        SAC_HOLD,
        SAC_CONV,
        SAC_DONE
    } sac_state_t;

    // Pin synchronisers
    logic [1:0] start_sync;
    logic [1:0] cmp_sync;
    logic [1:0] fast_sync;
    logic [1:0] range_sync;

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            start_sync <= 2'h0;
            cmp_sync   <= 2'h0;
            fast_sync  <= 2'h0;
            range_sync <= 2'h0;
        end else begin
            start_sync <= {start_sync[0], start_in};
            cmp_sync   <= {cmp_sync[0], cmp_in};
            fast_sync  <= {fast_sync[0], fast_in};
            range_sync <= {range_sync[0], range_in == sac_pkg::SAC_BIPOLAR};
        end
    end

    logic start_s;
    logic cmp_s;
    assign start_s = start_sync[1];
    assign cmp_s   = cmp_sync[1];

    function automatic logic [11:0] bit_period(input logic fast);
        bit_period = fast ? 12'(sac_pkg::BIT_FAST_CYC) : 12'(sac_pkg::BIT_SLOW_CYC);
    endfunction

    // Control state
    sac_state_t  state;
    sac_state_t  next_state;
    logic [11:0] tick;
    logic [11:0] next_tick;
    logic [3:0]  index;
    logic [3:0]  next_index;
    logic [11:0] period;
    logic [11:0] next_period;
    logic [7:0]  hold_cnt;
    logic [7:0]  next_hold_cnt;
    logic        status;
    logic        next_status;
    logic        short_start;
    logic        next_short_start;
    logic        sclk;
    logic        next_sclk;
    logic        sdata;
    logic        next_sdata;
    logic [11:0] result;
    logic [11:0] next_result;
    logic        bipolar;
    logic        next_bipolar;
    logic        sar_clear;
    logic        sar_decide;
    logic [11:0] code;

    sac_sar_reg u_sar (
        .clock_in  (clock_in),
        .rst_in    (rst_in),
        .clear_in  (sar_clear),
        .decide_in (sar_decide),
        .index_in  (index),
        .cmp_in    (cmp_s),
        .code_out  (code)
    );

    always_comb begin
        next_state       = state;
        next_tick        = tick;
        next_index       = index;
        next_period      = period;
        next_hold_cnt    = hold_cnt;
        next_status      = status;
        next_short_start = short_start;
        next_sclk        = 1'b1;
        next_sdata       = sdata;
        next_result      = result;
        next_bipolar     = bipolar;
        sar_clear        = 1'b0;
        sar_decide       = 1'b0;
        case (state)
            SAC_IDLE, SAC_DONE: begin
                // A start seen in the done cycle keeps status high with no dip
                next_status = 1'b0; // RQ2 RQ12
                if (start_s) begin
                    next_state    = SAC_HOLD; // RQ1
                    next_status   = 1'b1; // RQ2
                    next_hold_cnt = 8'h1;
                end
            end
            SAC_HOLD: begin
                next_status = 1'b1; // RQ2
                sar_clear   = 1'b1;
                if (hold_cnt != 8'hff) begin
                    next_hold_cnt = hold_cnt + 8'h1;
                end
                if (!start_s) begin
                    // Start too short is flagged but still honoured
                    next_short_start = (hold_cnt < 8'(sac_pkg::START_MIN_CYC)); // RQ1
                    next_state       = SAC_CONV; // RQ1
                    next_tick        = 12'h0;
                    next_index       = 4'hb; // RQ4
                    next_period      = bit_period(fast_sync[1]); // RQ11
                    next_bipolar     = range_sync[1];
                    next_result      = sac_pkg::RESULT_RST; // RQ3
                end
            end
            SAC_CONV: begin
                next_status = 1'b1; // RQ2
                next_tick   = tick + 12'h1;
                // Clock low in the first slots of each bit period
                next_sclk   = (tick >= 12'(sac_pkg::CLK_LOW_CYC)); // RQ10
                if (tick == period - 12'h1) begin
                    // Decision at end of the bit period
                    sar_decide = 1'b1; // RQ8
                    next_sdata = cmp_s; // RQ8 RQ9
                    next_tick  = 12'h0;
                    if (index == 4'h0) begin
                        next_state = SAC_DONE; // RQ12
                        next_sclk  = 1'b1;
                    end else begin
                        next_index = index - 4'h1;
                    end
                end
                if (start_s) begin
                    next_state    = SAC_HOLD; // RQ1
                    next_hold_cnt = 8'h1;
                    next_sclk     = 1'b1;
                end
            end
            default: begin
                next_state = SAC_IDLE;
            end
        endcase
        // Latch result once last decision has settled
        if (state == SAC_DONE && status) begin
            next_result = code; // RQ3 RQ5 RQ6
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state       <= SAC_IDLE;
            tick        <= 12'h0;
            index       <= 4'h0;
            period      <= 12'h0;
            hold_cnt    <= 8'h0;
            status      <= 1'b0;
            short_start <= 1'b0;
            sclk        <= 1'b1;
            sdata       <= 1'b0;
            result      <= sac_pkg::RESULT_RST;
            bipolar     <= 1'b0;
        end else begin
            state       <= next_state;
            tick        <= next_tick;
            index       <= next_index;
            period      <= next_period;
            hold_cnt    <= next_hold_cnt;
            status      <= next_status;
            short_start <= next_short_start;
            sclk        <= next_sclk;
            sdata       <= next_sdata;
            result      <= next_result;
            bipolar     <= next_bipolar;
        end
    end

    // Output registers
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            // Inverted MSB pin agrees with the cleared result from reset on
            result_out      <= '{data: sac_pkg::RESULT_RST, msb_inv: ~sac_pkg::RESULT_RST[11]}; // RQ7
            serial_out      <= '{sdata: 1'b0, sclk: 1'b1};
            status_out      <= 1'b0;
            short_start_out <= 1'b0;
            dac_code_out    <= sac_pkg::RESULT_RST;
        end else begin
            result_out.data    <= next_result; // RQ3
            result_out.msb_inv <= ~next_result[11]; // RQ7
            serial_out.sdata   <= next_sdata; // RQ8
            serial_out.sclk    <= next_sclk; // RQ10
            status_out         <= next_status; // RQ2
            short_start_out    <= next_short_start;
            dac_code_out       <= code;
        end
    end

endmodule

//--- sim/sac_cmp_model.sv
// Purpose: Analog side stand-in: comparator against a held target code
// Assumes: Trial code comes registered from the block
// Notes:   slow_in adds one register of lag to the answer
`timescale 1ns/100ps
module sac_cmp_model (
    // Clock and pace
    input  wire logic        clock_in,
    input  wire logic        slow_in,
    // Trial and target codes
    input  wire logic [11:0] dac_code_in,
    input  wire logic [11:0] target_in,
    // Comparator answer
    output logic             cmp_out
);
    logic cmp_q;
    always_ff @(posedge clock_in) begin
        cmp_q <= (dac_code_in <= target_in);
    end
    // Keep the trial bit while it does not pass the target
    assign cmp_out = slow_in ? cmp_q : (dac_code_in <= target_in);
endmodule

//--- sim/sac_ctrl_properties.sv
// Purpose: Concurrent checks on the converter control pins
// Assumes: One clock domain, synchronous reset
// Notes:   Conversion time and pulse count use helper counters
`timescale 1ns/100ps
module sac_ctrl_properties (
    // Clock and reset
    input  wire logic                 clock_in,
    input  wire logic                 rst_in,
    // Inputs of the block
    input  wire logic                 start_in,
    input  wire logic                 fast_in,
    input  wire sac_pkg::sac_range_t  range_in,
    input  wire logic                 cmp_in,
    // Outputs of the block
    input  wire logic [11:0]          dac_code_out,
    input  wire logic                 status_out,
    input  wire sac_pkg::sac_result_t result_out,
    input  wire sac_pkg::sac_serial_t serial_out,
    input  wire logic                 short_start_out
);
    logic [11:0] conv_cnt;
    logic [3:0]  pulse_cnt;
    logic        sclk_q;
    default clocking dcb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    always_ff @(posedge clock_in) begin
        sclk_q <= serial_out.sclk;
        if (rst_in || start_in || !status_out)
            conv_cnt <= 12'h000;
        else
            conv_cnt <= conv_cnt + 12'h001;
        if (rst_in || start_in)
            pulse_cnt <= 4'h0;
        else if (sclk_q && !serial_out.sclk)
            pulse_cnt <= pulse_cnt + 4'h1;
    end
    sequence s_low_pulse;
        !serial_out.sclk [*4] ##1 serial_out.sclk;
    endsequence
    property p_status_hold;
        start_in [*5] |-> status_out;
    endproperty
    property p_result_held;
        !status_out ##1 !status_out |-> $stable(result_out);
    endproperty
    property p_msb_inv;
        $fell(status_out) |-> ##[0:1] (result_out.msb_inv == !result_out.data[11]);
    endproperty
    property p_sclk_idle;
        !status_out |-> serial_out.sclk;
    endproperty
    property p_sclk_low;
        $fell(serial_out.sclk) |-> s_low_pulse;
    endproperty
    property p_sdata_steady;
        !serial_out.sclk && !sclk_q |-> $stable(serial_out.sdata);
    endproperty
    property p_conv_time;
        status_out |-> conv_cnt <= (fast_in ? sac_pkg::CONV_FAST_CYC + 4 : sac_pkg::CONV_SLOW_CYC + 4);
    endproperty
    property p_pulse_count;
        $fell(status_out) |-> pulse_cnt == 4'hc;
    endproperty
    a_status_hold: assert property (p_status_hold)
        else $error("status low while start held");
    a_result_held: assert property (p_result_held)
        else $error("result moved while idle");
    a_msb_inv: assert property (p_msb_inv)
        else $error("msb output not inverse of first bit");
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("clock out low outside conversion");
    a_sclk_low: assert property (p_sclk_low)
        else $error("clock out low pulse width wrong");
    a_sdata_steady: assert property (p_sdata_steady)
        else $error("serial bit moved during clock pulse");
    a_conv_time: assert property (p_conv_time)
        else $error("conversion too long");
    a_pulse_count: assert property (p_pulse_count)
        else $error("clock pulse count not twelve");
endmodule

//--- sim/tb_sac_ctrl.sv
// Purpose: Self-checking bench for the converter control block
// Assumes: Comparator stand-in resolves to the target code
// Notes:   Results are noted in a queue and checked when status falls
`timescale 1ns/100ps
module tb_sac_ctrl;
    typedef struct packed {
        logic [11:0] data;
        logic        short_flag;
    } sac_note_t;
    logic                 clock_in = 1'b0;
    logic                 rst_in, start_in, fast_in, cmp_in, slow;
    logic                 status_out, status_q, sclk_q, short_start_out;
    sac_pkg::sac_range_t  range_in;
    logic [11:0]          dac_code_out, target, serial_sr;
    logic [31:0]          seed;
    sac_pkg::sac_result_t result_out;
    sac_pkg::sac_serial_t serial_out;
    sac_note_t            note_q[$];
    int                   errors, tests_run;
    logic [11:0]          fixed[7] = '{12'h000, 12'h001, 12'he00, 12'h800, 12'h200, 12'h7ff, 12'hfff};
    sac_ctrl u_sac_ctrl (.clock_in(clock_in), .rst_in(rst_in), .start_in(start_in), .fast_in(fast_in),
        .range_in(range_in), .cmp_in(cmp_in), .dac_code_out(dac_code_out), .status_out(status_out),
        .result_out(result_out), .serial_out(serial_out), .short_start_out(short_start_out));
    sac_cmp_model u_sac_cmp_model (.clock_in(clock_in), .slow_in(slow), .dac_code_in(dac_code_out),
        .target_in(target), .cmp_out(cmp_in));
    always #2 clock_in = ~clock_in;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] want);
        tests_run++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic close_out();
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Mode 0 converts fully, 1 is cut by the next start, 2 by a reset
    task automatic convert(input logic [11:0] tgt, input int hold, input int mode);
        int n;
        seed = xs(seed);
        target = tgt;
        fast_in = seed[0];
        range_in = sac_pkg::sac_range_t'(seed[1]);
        slow = seed[2];
        start_in = 1'b1;
        repeat (hold) @(negedge clock_in);
        check({11'h000, status_out}, 12'h001);
        start_in = 1'b0;
        if (mode == 0)
            note_q.push_back({tgt, hold < sac_pkg::START_MIN_CYC});
        repeat (300) @(negedge clock_in);
        check({11'h000, status_out}, 12'h001);
        if (mode == 2) begin
            rst_in = 1'b1;
            repeat (3) @(negedge clock_in);
            rst_in = 1'b0;
            check({11'h000, serial_out.sclk}, 12'h001);
        end
        n = 0;
        while (mode == 0 && status_out !== 1'b0 && n < 2500) begin
            @(negedge clock_in);
            n++;
        end
        if (mode == 0) begin
            if (n >= 2500)
                check({11'h000, status_out}, 12'h000);
            repeat (20) @(negedge clock_in);
            target = ~tgt;
            repeat (40) @(negedge clock_in);
            check(result_out.data, tgt);
        end
    endtask
    always @(negedge clock_in) begin
        if (!rst_in && sclk_q && !serial_out.sclk)
            serial_sr = {serial_sr[10:0], serial_out.sdata};
        if (!rst_in && status_q && !status_out) begin
            serial_sr = {serial_sr[10:0], serial_out.sdata};
            if (note_q.size() == 0)
                check(12'h000, 12'hfff);
            else begin
                check(result_out.data, note_q[0].data);
                check({11'h000, result_out.msb_inv}, {11'h000, ~note_q[0].data[11]});
                check(serial_sr, note_q[0].data);
                check({11'h000, short_start_out}, {11'h000, note_q[0].short_flag});
                void'(note_q.pop_front());
            end
        end
        status_q = status_out;
        sclk_q = serial_out.sclk;
    end
    initial begin
        rst_in = 1'b1;
        start_in = 1'b0;
        fast_in = 1'b0;
        slow = 1'b0;
        range_in = sac_pkg::SAC_UNIPOLAR;
        target = 12'h000;
        serial_sr = 12'h000;
        seed = 32'hbecd;
        errors = 0;
        tests_run = 0;
        repeat (3) @(negedge clock_in);
        rst_in = 1'b0;
        foreach (fixed[i]) convert(fixed[i], 30, 0);
        convert(12'h555, 24, 0);
        convert(12'haaa, 25, 0);
        convert(12'h123, 10, 1);
        convert(12'h321, 40, 0);
        convert(12'h456, 30, 2);
        repeat (8) begin
            seed = xs(seed);
            convert(seed[15:4], 25 + int'(seed[3:0]), 0);
        end
        // Every noted conversion must have ended with a status fall
        check(12'(note_q.size()), 12'h000);
        close_out();
    end
    // Twenty conversions need under 40k cycles
    initial begin
        #300000;
        errors++;
        close_out();
    end
endmodule
bind sac_ctrl sac_ctrl_properties u_sac_ctrl_properties (.clock_in(clock_in), .rst_in(rst_in),
    .start_in(start_in), .fast_in(fast_in), .range_in(range_in), .cmp_in(cmp_in),
    .dac_code_out(dac_code_out), .status_out(status_out), .result_out(result_out),
    .serial_out(serial_out), .short_start_out(short_start_out));
